// ==== design/scp_pkg.sv ====
// package: register map, reset values and shared types of the system config block
package scp_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_CLK_GATE_1 = 16'h1C02; // peripheral_clock_gate_ctrl_1
  localparam logic [15:0] IDX_CLK_GATE_2 = 16'h1C03; // peripheral_clock_gate_ctrl_2
  localparam logic [15:0] IDX_EDGE_RATE = 16'h1C16; // output_edge_rate_ctrl
  localparam logic [15:0] IDX_PULL_1 = 16'h1C17; // pull_resistor_inhibit_1
  localparam logic [15:0] IDX_PULL_2 = 16'h1C18; // pull_resistor_inhibit_2
  localparam logic [15:0] IDX_PULL_3 = 16'h1C19; // pull_resistor_inhibit_3
  localparam logic [15:0] IDX_USB_SYS = 16'h1C32; // usb_system_ctrl
  localparam logic [15:0] IDX_EXT_SYS = 16'h1C33; // ext_memory_system_ctrl
  localparam logic [15:0] IDX_BOOT = 16'h1C34; // boot_method_latch, read only
  localparam logic [15:0] IDX_PULL_4 = 16'h1C4C; // pull_resistor_inhibit_4
  localparam logic [15:0] IDX_PULL_5 = 16'h1C4D; // pull_resistor_inhibit_5
  localparam logic [15:0] IDX_PULL_6 = 16'h1C4F; // pull_resistor_inhibit_6
  localparam logic [15:0] IDX_PULL_7 = 16'h1C50; // pull_resistor_inhibit_7
  localparam logic [15:0] IDX_PIN_SEL = 16'h1C60; // external_bus_pin_select
  localparam logic [15:0] IDX_STATUS = 16'h1C61; // block status, read only
  localparam logic [15:0] IDX_REG_CTRL = 16'h7004; // regulator_ctrl

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PIN_HI1_BIT = 1; // addr_line_hi1_pin_select
  localparam int PIN_HI0_BIT = 0; // addr_line_hi0_pin_select
  localparam int VSEL_BIT = 1; // core_regulator_voltage_select
  localparam int USB_REG_BIT = 0; // usb_regulator_enable
  localparam int BYTE_LSB = 0; // byte_access_select low bit
  localparam int USB_OSC_OFF_BIT = 2; // usb oscillator disable
  localparam int SLEW_CLOCK_OUTPUT_PIN_BIT = 0; // clock_output_pin slow edges
  localparam int SLEW_EMIF_BIT = 1; // external memory pins slow edges
  localparam int BOOT_W = 6; // boot_method_latch width
  localparam int PULL_REGS = 7; // number of pull inhibit registers

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [15:0] PIN_SEL_RST = 16'h003F; // all shared pins as gpio
  localparam logic [15:0] REG_CTRL_RST = 16'h0000; // 1.3 v, usb regulator off
  localparam logic [15:0] USB_SYS_RST = 16'h0004; // word access, oscillator off
  localparam logic [15:0] EXT_SYS_RST = 16'h0000; // word access
  localparam logic [15:0] CLK_GATE_RST = 16'h0000; // all clocks running
  localparam logic [15:0] EDGE_RATE_RST = 16'h0000; // fast edges
  localparam logic [15:0] PULL_RST = 16'h0000; // pulls enabled
  localparam logic VSEL_1V30 = 1'b0; // select code for 1.3 v
  localparam logic [3:0] BOOT_SAMPLE_CYC = 4'hA; // cycles after release to sample

  // ************************************************************
  // bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte access modes
  typedef enum logic [1:0] {
    SCP_BYTE_WORD = 2'b00,
    SCP_BYTE_HIGH = 2'b01,
    SCP_BYTE_LOW = 2'b10,
    SCP_BYTE_RSVD = 2'b11
  } scp_byte_mode_t;

  // boot sampling states
  typedef enum logic [1:0] {
    SCP_BOOT_WAIT = 2'b00,
    SCP_BOOT_DONE = 2'b01
  } scp_boot_state_t;

  // drive of one shared pad
  typedef struct packed {
    logic out; // level driven
    logic oe; // high while driven
  } scp_drive_t;

endpackage : scp_pkg

// ==== design/scp_sync2.sv ====
// module: two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module scp_sync2
  import scp_pkg::*;
#(
  parameter int W = 1
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg; // first stage, read only by second stage

  // ************************************************************
  // two-stage capture
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : scp_sync2

// ==== design/scp_pin_mux_cell.sv ====
// module: selects memory address or gpio drive for one shared pad
`timescale 1ns/1ps
module scp_pin_mux_cell
  import scp_pkg::*;
(
  input wire logic sel_gpio,
  input wire logic hold_input,
  input wire logic addr_bit,
  input wire scp_drive_t gpio_drv,
  output scp_drive_t pad_drv
);

  // ************************************************************
  // pad source select
  // ************************************************************
  always_comb
  begin
    if (hold_input)
    begin
      pad_drv = '{out: 1'b0, oe: 1'b0}; // boot sampling keeps pad an input
    end
    else if (sel_gpio)
    begin
      pad_drv = gpio_drv; // gpio owns the pad
    end
    else
    begin
      pad_drv = '{out: addr_bit, oe: 1'b1}; // memory address always driven
    end
  end

endmodule : scp_pin_mux_cell

// ==== design/scp_sys_config.sv ====
// module: system configuration register bank, pin mux and clock select
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module scp_sys_config
  import scp_pkg::*;
#(
  parameter int ADDR_W = 17
)(
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and straps
  input wire logic [BOOT_W-1:0] shared_pad_in,
  output logic [1:0] shared_pad_out,
  output logic [1:0] shared_pad_oe,
  input wire logic [1:0] ext_memory_address_pin,
  input wire logic [1:0] general_io_pin_out,
  input wire logic [1:0] general_io_pin_oe,
  output logic [1:0] general_io_pin_in,
  input wire logic clock_source_strap,
  input wire logic core_regulator_enable_strap_n,
  input wire logic core_power_on,
  input wire logic rtc_osc_running,
  // configuration outputs
  output logic core_regulator_1v05,
  output logic usb_regulator_on,
  output logic usb_osc_on,
  output logic sysclk_from_ext_ref,
  output logic rtc_regs_accessible,
  output logic [1:0] ext_memory_byte_mode,
  output logic [1:0] usb_byte_mode,
  output logic [31:0] peripheral_clock_gate,
  output logic [1:0] slow_edge_select,
  output logic [PULL_REGS-1:0][15:0] pull_enable,
  output logic bus_holder_enable
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [BOOT_W-1:0] pad_sync; // synchronised pad levels
  logic [3:0] misc_sync; // synchronised straps and power levels
  logic strap_sync; // clock-source strap
  logic ldo_strap_n_sync; // core regulator enable strap
  logic core_on_sync; // core power good
  logic rtc_on_sync; // rtc oscillator running
  scp_boot_state_t boot_state_reg; // boot sampling state
  logic [3:0] boot_cnt_reg; // cycles since reset release
  logic [BOOT_W-1:0] boot_latch_reg; // boot_method_latch
  logic strap_hi_reg; // strap level caught with boot sample
  logic [15:0] pin_sel_reg; // external_bus_pin_select
  logic [15:0] reg_ctrl_reg; // regulator_ctrl
  logic [15:0] usb_sys_reg; // usb_system_ctrl
  logic [15:0] ext_sys_reg; // ext_memory_system_ctrl
  logic [15:0] gate1_reg; // peripheral_clock_gate_ctrl_1
  logic [15:0] gate2_reg; // peripheral_clock_gate_ctrl_2
  logic [15:0] edge_reg; // output_edge_rate_ctrl
  logic [15:0] pull_inh_reg [PULL_REGS]; // pull_resistor_inhibit_1..7
  logic aw_held_reg; // write address captured
  logic w_held_reg; // write data captured
  logic [15:0] aw_idx_reg; // captured write index
  logic [15:0] wdata_reg; // captured low half of write data
  logic [1:0] wstrb_reg; // captured low lanes
  logic aw_held_next; // next write address held
  logic w_held_next; // next write data held
  logic rvalid_next; // next read valid
  logic wr_fire; // perform write this cycle
  logic wr_hit; // write index is mapped, read-only registers included
  logic [15:0] wmask; // lane mask of the write
  logic [15:0] rd_idx; // read index
  logic [15:0] rd_word; // read mux result
  logic rd_hit; // read index is mapped
  logic usb_reg_eff; // usb regulator after strap force
  logic [15:0] status_word; // status register content
  scp_drive_t drv [2]; // per-pad drive from mux cells

  // ************************************************************
  // synchronisers for pins and straps
  // ************************************************************
  scp_sync2 #(.W(BOOT_W)) u_pad_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(shared_pad_in),
    .q(pad_sync)
  );

  scp_sync2 #(.W(4)) u_misc_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({clock_source_strap, core_regulator_enable_strap_n, core_power_on, rtc_osc_running}),
    .q(misc_sync)
  );

  assign strap_sync = misc_sync[3];
  assign ldo_strap_n_sync = misc_sync[2];
  assign core_on_sync = misc_sync[1];
  assign rtc_on_sync = misc_sync[0];

  // ************************************************************
  // boot sampling
  // ************************************************************
  // count from release, capture once, then hold until the next reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      boot_state_reg <= SCP_BOOT_WAIT;
      boot_cnt_reg <= 4'h0;
      boot_latch_reg <= '0;
      strap_hi_reg <= 1'b0;
    end
    else
    begin
      case (boot_state_reg)
        SCP_BOOT_WAIT:
        begin
          boot_cnt_reg <= boot_cnt_reg + 4'h1;
          if (boot_cnt_reg == BOOT_SAMPLE_CYC - 4'h1)
          begin
            boot_latch_reg <= pad_sync;
            strap_hi_reg <= strap_sync;
            boot_state_reg <= SCP_BOOT_DONE;
          end
        end
        SCP_BOOT_DONE:
        begin
          boot_state_reg <= SCP_BOOT_DONE;
        end
        default:
        begin
          boot_state_reg <= SCP_BOOT_DONE;
        end
      endcase
    end
  end

  // ************************************************************
  // axi write channel
  // ************************************************************
  assign aw_held_next = (s_axi_awvalid && s_axi_awready) ? 1'b1 : (wr_fire ? 1'b0 : aw_held_reg);
  assign w_held_next = (s_axi_wvalid && s_axi_wready) ? 1'b1 : (wr_fire ? 1'b0 : w_held_reg);
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // decode of mapped write indices, read-only ones included
  always_comb
  begin
    case (aw_idx_reg)
      IDX_CLK_GATE_1, IDX_CLK_GATE_2, IDX_EDGE_RATE, IDX_USB_SYS, IDX_EXT_SYS,
      IDX_PIN_SEL, IDX_REG_CTRL, IDX_PULL_1, IDX_PULL_2, IDX_PULL_3,
      IDX_PULL_4, IDX_PULL_5, IDX_PULL_6, IDX_PULL_7, IDX_BOOT, IDX_STATUS:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // address and data capture, response after both
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      s_axi_awready <= !aw_held_next;
      s_axi_wready <= !w_held_next;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx_reg <= 16'(s_axi_awaddr[ADDR_W-1:2]);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg <= s_axi_wdata[15:0];
        wstrb_reg <= s_axi_wstrb[1:0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  // control registers, lane-merged writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_sel_reg <= PIN_SEL_RST;
      reg_ctrl_reg <= REG_CTRL_RST;
      usb_sys_reg <= USB_SYS_RST;
      ext_sys_reg <= EXT_SYS_RST;
      gate1_reg <= CLK_GATE_RST;
      gate2_reg <= CLK_GATE_RST;
      edge_reg <= EDGE_RATE_RST;
    end
    else if (wr_fire)
    begin
      case (aw_idx_reg)
        IDX_PIN_SEL: pin_sel_reg <= (pin_sel_reg & ~wmask) | (wdata_reg & wmask);
        IDX_REG_CTRL: reg_ctrl_reg <= (reg_ctrl_reg & ~wmask) | (wdata_reg & wmask);
        IDX_USB_SYS: usb_sys_reg <= (usb_sys_reg & ~wmask) | (wdata_reg & wmask);
        IDX_EXT_SYS: ext_sys_reg <= (ext_sys_reg & ~wmask) | (wdata_reg & wmask);
        IDX_CLK_GATE_1: gate1_reg <= (gate1_reg & ~wmask) | (wdata_reg & wmask);
        IDX_CLK_GATE_2: gate2_reg <= (gate2_reg & ~wmask) | (wdata_reg & wmask);
        IDX_EDGE_RATE: edge_reg <= (edge_reg & ~wmask) | (wdata_reg & wmask);
        default: ;
      endcase
    end
  end

  // pull inhibit bank
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PULL_REGS; i++)
      begin
        pull_inh_reg[i] <= PULL_RST;
      end
    end
    else if (wr_fire)
    begin
      case (aw_idx_reg)
        IDX_PULL_1: pull_inh_reg[0] <= (pull_inh_reg[0] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_2: pull_inh_reg[1] <= (pull_inh_reg[1] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_3: pull_inh_reg[2] <= (pull_inh_reg[2] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_4: pull_inh_reg[3] <= (pull_inh_reg[3] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_5: pull_inh_reg[4] <= (pull_inh_reg[4] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_6: pull_inh_reg[5] <= (pull_inh_reg[5] & ~wmask) | (wdata_reg & wmask);
        IDX_PULL_7: pull_inh_reg[6] <= (pull_inh_reg[6] & ~wmask) | (wdata_reg & wmask);
        default: ;
      endcase
    end
  end

  // ************************************************************
  // axi read channel
  // ************************************************************
  assign rd_idx = 16'(s_axi_araddr[ADDR_W-1:2]);
  assign rvalid_next = (s_axi_arvalid && s_axi_arready) ? 1'b1 :
                       (s_axi_rready ? 1'b0 : s_axi_rvalid);
  // strap low forces the usb regulator on, readback shows it
  assign usb_reg_eff = reg_ctrl_reg[USB_REG_BIT] || !strap_hi_reg;
  assign status_word = {11'h000, !ldo_strap_n_sync, rtc_on_sync, core_on_sync,
                        (boot_state_reg == SCP_BOOT_DONE), strap_hi_reg};

  // read mux
  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_CLK_GATE_1: rd_word = gate1_reg;
      IDX_CLK_GATE_2: rd_word = gate2_reg;
      IDX_EDGE_RATE: rd_word = edge_reg;
      IDX_USB_SYS: rd_word = usb_sys_reg;
      IDX_EXT_SYS: rd_word = ext_sys_reg;
      IDX_BOOT: rd_word = 16'(boot_latch_reg);
      IDX_PIN_SEL: rd_word = pin_sel_reg;
      IDX_STATUS: rd_word = status_word;
      IDX_REG_CTRL: rd_word = {reg_ctrl_reg[15:1], usb_reg_eff};
      IDX_PULL_1: rd_word = pull_inh_reg[0];
      IDX_PULL_2: rd_word = pull_inh_reg[1];
      IDX_PULL_3: rd_word = pull_inh_reg[2];
      IDX_PULL_4: rd_word = pull_inh_reg[3];
      IDX_PULL_5: rd_word = pull_inh_reg[4];
      IDX_PULL_6: rd_word = pull_inh_reg[5];
      IDX_PULL_7: rd_word = pull_inh_reg[6];
      default:
      begin
        rd_word = 16'h0000; // unmapped reads zero with error
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read in flight, answer one cycle after address
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // shared pad multiplexing
  // ************************************************************
  // bit 1: address 16 or gpio 22
  scp_pin_mux_cell u_mux_hi1 (
    .sel_gpio(pin_sel_reg[PIN_HI1_BIT]),
    .hold_input(boot_state_reg != SCP_BOOT_DONE),
    .addr_bit(ext_memory_address_pin[1]),
    .gpio_drv('{out: general_io_pin_out[1], oe: general_io_pin_oe[1]}),
    .pad_drv(drv[1])
  );

  // bit 0: address 15 or gpio 21
  scp_pin_mux_cell u_mux_hi0 (
    .sel_gpio(pin_sel_reg[PIN_HI0_BIT]),
    .hold_input(boot_state_reg != SCP_BOOT_DONE),
    .addr_bit(ext_memory_address_pin[0]),
    .gpio_drv('{out: general_io_pin_out[0], oe: general_io_pin_oe[0]}),
    .pad_drv(drv[0])
  );

  // registered pad drive, a stable select keeps the pad steady
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shared_pad_out <= 2'h0;
      shared_pad_oe <= 2'h0;
      general_io_pin_in <= 2'h0;
    end
    else
    begin
      shared_pad_out <= {drv[1].out, drv[0].out};
      shared_pad_oe <= {drv[1].oe, drv[0].oe};
      general_io_pin_in <= pad_sync[1:0];
    end
  end

  // ************************************************************
  // regulators and clock sources
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      core_regulator_1v05 <= 1'b0;
      usb_regulator_on <= 1'b1;
      usb_osc_on <= 1'b1;
      sysclk_from_ext_ref <= 1'b0;
      rtc_regs_accessible <= 1'b0;
    end
    else
    begin
      // voltage bit only acts with the regulator strapped on
      core_regulator_1v05 <= !ldo_strap_n_sync && (reg_ctrl_reg[VSEL_BIT] != VSEL_1V30);
      usb_regulator_on <= usb_reg_eff;
      // strap low locks the oscillator on
      usb_osc_on <= !strap_hi_reg || !usb_sys_reg[USB_OSC_OFF_BIT];
      sysclk_from_ext_ref <= strap_hi_reg;
      rtc_regs_accessible <= rtc_on_sync;
    end
  end

  // ************************************************************
  // pad configuration outputs
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_memory_byte_mode <= SCP_BYTE_WORD;
      usb_byte_mode <= SCP_BYTE_WORD;
      peripheral_clock_gate <= 32'h00000000;
      slow_edge_select <= 2'h0;
      pull_enable <= '0;
      bus_holder_enable <= 1'b1;
    end
    else
    begin
      ext_memory_byte_mode <= ext_sys_reg[BYTE_LSB+1:BYTE_LSB];
      usb_byte_mode <= usb_sys_reg[BYTE_LSB+1:BYTE_LSB];
      peripheral_clock_gate <= {gate2_reg, gate1_reg};
      slow_edge_select <= {edge_reg[SLEW_EMIF_BIT], edge_reg[SLEW_CLOCK_OUTPUT_PIN_BIT]};
      for (int i = 0; i < PULL_REGS; i++)
      begin
        pull_enable[i] <= core_on_sync ? ~pull_inh_reg[i] : 16'h0000;
      end
      bus_holder_enable <= !core_on_sync;
    end
  end

endmodule : scp_sys_config

// ==== testbench/scp_sys_config_chk.sv ====
// checker: bus and configuration assertions of the system config block
`timescale 1ns/1ps
module scp_sys_config_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic clock_source_strap,
  input wire logic usb_regulator_on,
  input wire logic usb_osc_on,
  input wire logic core_power_on,
  input wire logic bus_holder_enable,
  input wire logic core_regulator_1v05,
  input wire logic [1:0] shared_pad_oe,
  input wire logic [1:0] ext_memory_byte_mode,
  input wire logic [1:0] usb_byte_mode
);
  logic [3:0] cnt_reg; // edges since reset release
  // saturating count of edges after release
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hF)
      cnt_reg <= cnt_reg + 4'h1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_write_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_usb_forced: assert property (!clock_source_strap [*4] |-> usb_regulator_on && usb_osc_on)
    else $error("usb supply off with strap low");
  a_holder_power: assert property (!core_power_on [*4] |-> bus_holder_enable)
    else $error("holder off without core power");
  a_pads_input: assert property (cnt_reg < 4'h9 |-> shared_pad_oe == 2'h0)
    else $error("pad driven before boot sample");
  a_word_access: assert property (cnt_reg < 4'h9 |-> (ext_memory_byte_mode | usb_byte_mode) == 2'h0)
    else $error("byte mode not word after reset");
  a_boot_voltage: assert property (cnt_reg < 4'h9 |-> !core_regulator_1v05)
    else $error("core voltage not 1.3 v at boot");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (!core_power_on);
endmodule : scp_sys_config_chk
bind scp_sys_config scp_sys_config_chk chk_i (.*);

// ==== testbench/tb_scp_sys_config.sv ====
// testbench: self-checking bench of the system config block
`timescale 1ns/1ps
module tb_scp_sys_config import scp_pkg::*;;
  logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic clock_source_strap, core_regulator_enable_strap_n, core_power_on, rtc_osc_running;
  logic core_regulator_1v05, usb_regulator_on, usb_osc_on, sysclk_from_ext_ref;
  logic rtc_regs_accessible, bus_holder_enable;
  logic [16:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, peripheral_clock_gate;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, shared_pad_out, shared_pad_oe, ext_memory_address_pin;
  logic [1:0] general_io_pin_out, general_io_pin_oe, general_io_pin_in, ext_memory_byte_mode;
  logic [1:0] usb_byte_mode, slow_edge_select;
  logic [5:0] shared_pad_in;
  logic [6:0][15:0] pull_enable;
  logic [15:0] pidx [7] = '{IDX_PULL_1, IDX_PULL_2, IDX_PULL_3, IDX_PULL_4, IDX_PULL_5,
    IDX_PULL_6, IDX_PULL_7};
  int n_mismatch, n_tests;
  scp_sys_config uut (.*);
  // 200 mhz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task print_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task settle;
    repeat (6) @(posedge core_clk);
  endtask : settle
  // bus write, readies sampled at the edge
  task wr(input logic [15:0] i, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    s_axi_awaddr <= 17'({i, 2'b00});
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 40) begin n_mismatch++; print_verdict; end
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask : wr
  // bus read with expected word and response
  task rd(input logic [15:0] i, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    int k;
    s_axi_araddr <= 17'({i, 2'b00});
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 40) begin n_mismatch++; print_verdict; end
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata);
  endtask : rd
  task do_reset(input logic s);
    clock_source_strap <= s;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (14) @(posedge core_clk);
  endtask : do_reset
  task s_boot_regs;
    rd(IDX_BOOT, 32'h2A);
    shared_pad_in <= 6'h15;
    wr(IDX_BOOT, 32'h3);
    rd(IDX_BOOT, 32'h2A);
    chk("gpio_in", 32'h1, {30'h0, general_io_pin_in});
    rd(IDX_PIN_SEL, {16'h0, PIN_SEL_RST});
    rd(IDX_REG_CTRL, 32'h1);
    rd(IDX_USB_SYS, {16'h0, USB_SYS_RST});
    rd(IDX_EXT_SYS, 32'h0);
    rd(16'h1C01, 32'h0, RESP_SLVERR);
    wr(16'h1C01, 32'h1, RESP_SLVERR);
  endtask : s_boot_regs
  task s_pins;
    logic [1:0] j;
    ext_memory_address_pin <= 2'b11;
    for (j = 2'h1; j < 2'h3; j++)
    begin
      wr(IDX_PIN_SEL, {30'h0, j});
      settle;
      chk("pad_out", {30'h0, ~j}, {30'h0, shared_pad_out});
      chk("pad_oe", {30'h0, ~j}, {30'h0, shared_pad_oe});
    end
  endtask : s_pins
  task s_ctrl;
    wr(IDX_REG_CTRL, 32'h2);
    wr(IDX_EXT_SYS, 32'h1);
    wr(IDX_USB_SYS, 32'h6);
    wr(IDX_EDGE_RATE, 32'h1);
    wr(IDX_CLK_GATE_1, 32'h1234);
    s_axi_wstrb <= 4'h2;
    wr(IDX_CLK_GATE_2, 32'hABCD);
    s_axi_wstrb <= 4'hF;
    settle;
    chk("gate", 32'hAB001234, peripheral_clock_gate);
    chk("ext_ref", 32'h0, {31'h0, sysclk_from_ext_ref});
    chk("v105", 32'h1, {31'h0, core_regulator_1v05});
    chk("usb_reg", 32'h1, {31'h0, usb_regulator_on});
    chk("usb_osc", 32'h1, {31'h0, usb_osc_on});
    chk("ext_byte", 32'h1, {30'h0, ext_memory_byte_mode});
    chk("usb_byte", 32'h2, {30'h0, usb_byte_mode});
    chk("slew", 32'h1, {30'h0, slow_edge_select});
  endtask : s_ctrl
  task s_pull;
    for (int p = 0; p < 7; p++) wr(pidx[p], {28'h0, 4'(p)});
    settle;
    for (int p = 0; p < 7; p++) chk("pull", {16'h0, ~{12'h0, 4'(p)}}, {16'h0, pull_enable[p]});
    core_power_on <= 1'b0;
    rtc_osc_running <= 1'b0;
    settle;
    chk("pull_off", 32'h0, {16'h0, pull_enable[6]});
    chk("holder", 32'h1, {31'h0, bus_holder_enable});
    chk("rtc", 32'h0, {31'h0, rtc_regs_accessible});
    core_power_on <= 1'b1;
  endtask : s_pull
  task s_strap_high;
    do_reset(1'b1);
    chk("usb_reg", 32'h0, {31'h0, usb_regulator_on});
    chk("ext_ref", 32'h1, {31'h0, sysclk_from_ext_ref});
    chk("usb_osc", 32'h0, {31'h0, usb_osc_on});
    wr(IDX_REG_CTRL, 32'h1);
    wr(IDX_USB_SYS, 32'h0);
    settle;
    chk("usb_reg", 32'h1, {31'h0, usb_regulator_on});
    chk("usb_osc", 32'h1, {31'h0, usb_osc_on});
  endtask : s_strap_high
  initial
  begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, core_regulator_enable_strap_n} = '0;
    {s_axi_bready, s_axi_rready, core_power_on, rtc_osc_running} = '1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_memory_address_pin} = '0;
    {general_io_pin_out, general_io_pin_oe, clock_source_strap} = '0;
    s_axi_wstrb = 4'hF;
    shared_pad_in = 6'h2A;
    do_reset(1'b0);
    s_boot_regs;
    s_pins;
    s_ctrl;
    s_pull;
    s_strap_high;
    print_verdict;
  end
endmodule : tb_scp_sys_config
